// ==== shared/flash_ctrl_pkg.sv ====
// Package with register map, field positions, reset values and timing counts of the flash controller
package flash_ctrl_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CLKDIV  = 8'h00;
  localparam logic [7:0] ADDR_SEC     = 8'h04;
  localparam logic [7:0] ADDR_CNFG    = 8'h08;
  localparam logic [7:0] ADDR_ERCNFG  = 8'h0c;
  localparam logic [7:0] ADDR_STAT    = 8'h10;
  localparam logic [7:0] ADDR_ERSTAT  = 8'h14;
  localparam logic [7:0] ADDR_PPROT   = 8'h18;
  localparam logic [7:0] ADDR_EPROT   = 8'h1c;
  localparam logic [7:0] ADDR_OPT     = 8'h20;
  localparam logic [7:0] ADDR_CMDCODE = 8'h24;
  localparam logic [7:0] ADDR_CMDADDR = 8'h28;
  localparam logic [7:0] ADDR_MODE    = 8'h2c;
  localparam logic [7:0] ADDR_INFOROW = 8'h30;

  // Field positions
  localparam int BIT_DIVLD   = 7;
  localparam int BIT_CMD_COMPLETE_IRQ_EN    = 7;
  localparam int BIT_IGNORE_SINGLE_FAULT   = 4;
  localparam int BIT_FORCE_DOUBLE_FAULT    = 1;
  localparam int BIT_FORCE_SINGLE_FAULT    = 0;
  localparam int BIT_DOUBLE_FAULT_IRQ_EN   = 1;
  localparam int BIT_SINGLE_FAULT_IRQ_EN   = 0;
  localparam int BIT_CCF     = 7;
  localparam int BIT_ACCESS_ERROR_FLAG  = 5;
  localparam int BIT_PVIOL   = 4;
  localparam int BIT_DFDF    = 1;
  localparam int BIT_SFDF    = 0;
  localparam int BIT_NVMODE  = 4;
  localparam int BIT_PROT_HI = 0;
  localparam int BIT_PROT_LO = 1;
  localparam int BIT_PROT_MID = 2;
  localparam int DIV_W       = 6;

  // Program flash map and configuration field
  localparam logic [17:0] PFLASH_LO    = 18'h2_8000;
  localparam logic [17:0] PFLASH_HI    = 18'h3_ffff;
  localparam logic [17:0] LOWREG_START = 18'h3_8000;
  localparam logic [17:0] HIGHREG_TOP  = 18'h3_ffff;
  localparam logic [17:0] LOWREG_SIZE  = 18'h0_1000;
  localparam logic [17:0] HIGHREG_SIZE = 18'h0_1000;
  localparam logic [17:0] KEY_FIRST    = 18'h3_ff00;
  localparam logic [17:0] KEY_LAST     = 18'h3_ff07;
  localparam int          KEY_BYTES    = 8;
  localparam logic [17:0] CFG_FIRST    = 18'h3_ff0c;
  localparam logic [17:0] CFG_LAST     = 18'h3_ff0f;
  localparam logic [7:0]  RSVD_FILL    = 8'hff;

  // Fallback values: every region protected, device secured
  localparam logic [7:0] DEF_PPROT = 8'h07;
  localparam logic [7:0] DEF_EPROT = 8'h01;
  localparam logic [7:0] DEF_OPT   = 8'hff;
  localparam logic [7:0] DEF_SEC   = 8'h00;

  // Version field: 1 is the first version, 0 and 15 mean none
  localparam logic [3:0] VER_FIRST  = 4'h1;
  localparam logic [3:0] VER_NONE_0 = 4'h0;
  localparam logic [3:0] VER_NONE_1 = 4'hf;

  // Command codes
  localparam logic [7:0] CMD_ERSVFY_ALL = 8'h01;
  localparam logic [7:0] CMD_PGM_PF     = 8'h06;
  localparam logic [7:0] CMD_ERS_PFBLK  = 8'h09;
  localparam logic [7:0] CMD_VFY_KEY    = 8'h0c;
  localparam logic [7:0] CMD_PGM_EE     = 8'h11;

  // Cycle counts that stay below the parameter threshold
  localparam int OPC_PGM_PF   = 164;
  localparam int BUSC_PGM_PF  = 2925;
  localparam int OPC_PGM_EE   = 68;
  localparam int BUSC_PGM_EE  = 1565;
  localparam int OPC_VFY_KEY  = 0;
  localparam int BUSC_VFY_KEY = 481;
  localparam int OPC_ERSVFY   = 0;
  localparam int CNT_W        = 17;

  typedef enum logic [2:0] {
    ST_INIT_REQ  = 3'b000,
    ST_INIT_WAIT = 3'b001,
    ST_IDLE      = 3'b010,
    ST_EXEC_OP   = 3'b011,
    ST_EXEC_BUS  = 3'b100
  } ctrlState_t;

  // Answer from the flash array read port
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       singleFault;
    logic       doubleFault;
  } arrayResp_t;

endpackage

// ==== design/flash_command_protection_ctrl.sv ====
// Flash command sequencer with protection, configuration field load and fault reporting
// Notes on behaviour
// - Program flash occupies global addresses 0x2_8000 through 0x3_FFFF, config field inside.
// - Lower region grows up from 0x3_8000, higher down from 0x3_FFFF, rest third.
// - Eight-byte backdoor key lives at 0x3_FF00 through 0x3_FF07.
// - Four protection, option and security bytes live at 0x3_FF0C through 0x3_FF0F.
// - Version field: one is first version; all zeros and all ones mean none.
// - Information row reads only while nonvolatile resource mode is active.
// - Command complete interrupt follows the flag while its enable bit 7 is set.
// - Ignore bit 4 suppresses real (not forced) single fault reporting and its interrupt.
// - Force bit 1 makes every array read set double fault flag.
// - Force bit 0 makes every array read set single fault flag.
// - Error configuration enables gate the fault interrupt from the error flags; all assigned bits read and write.
// - Any divider write sets divider loaded flag; zero means unwritten since reset.
// - Program or erase without loaded divider is refused and sets access error.
// - While command complete is low, launches and command object writes are ignored.
// - Erase verify all takes zero operation cycles and 35345 bus cycles.
// - Program four words takes 164 operation cycles plus 2925 bus cycles.
// - Erase program flash block takes 100060 operation plus 33541 bus cycles.
// - Program one EEPROM word takes 68 operation plus 1565 bus cycles.
// - Backdoor key verify takes zero operation cycles and 481 bus cycles.
// - Reset loads protection, option, security from config field; double faults give defaults.
// - Command complete stays low during reset load, rises when it finishes.
// - Reset during a command aborts it at once.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module flash_command_protection_ctrl #(
  parameter int          BUSC_ERSVFY  = 35345,
  parameter int          OPC_ERS_PF   = 100060,
  parameter int          BUSC_ERS_PF  = 33541,
  parameter logic [3:0]  VERSION      = flash_ctrl_pkg::VER_FIRST,
  parameter logic [31:0] INFO_ROW     = 32'h0000_0000  // Arbitrary content
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Flash array read port
  output logic                           arrayReadReq,
  output logic      [17:0]               arrayAddr,
  input  wire flash_ctrl_pkg::arrayResp_t arrayResp,
  // Interrupt requests and status
  output logic                           cmdCompleteIrq,
  output logic                           faultIrq,
  output logic                           cmdBusy
);

  flash_ctrl_pkg::ctrlState_t state;
  logic [7:0]  pflashProt;
  logic [7:0]  eepromProt;
  logic [7:0]  optionByte;
  logic [7:0]  securityByte;
  logic [flash_ctrl_pkg::DIV_W-1:0] dividerValue;
  logic        dividerLoaded;
  logic        cmd_complete_irq_en;
  logic        ignoreSf;
  logic        forceDf;
  logic        forceSf;
  logic        dfIrqEn;
  logic        sfIrqEn;
  logic        cmdCompleteFlag;
  logic        accessError;
  logic        protViolation;
  logic        doubleFaultFlag;
  logic        singleFaultFlag;
  logic        nvMode;
  logic [7:0]  cmdCode;
  logic [17:0] cmdAddr;
  logic [1:0]  initIdx;
  logic        initFault;
  logic [7:0]  initBytes [4];
  logic [flash_ctrl_pkg::DIV_W-1:0] divCount;
  logic        opTick;
  logic [flash_ctrl_pkg::CNT_W-1:0] opLeft;
  logic [flash_ctrl_pkg::CNT_W-1:0] busLeft;

  logic        setupPhase;
  logic        wrStrobe;
  logic        knownAddr;
  logic        launchWrite;
  logic        launchOk;
  logic        isPgmErs;
  logic        isKnownCmd;
  logic        protHit;
  logic [flash_ctrl_pkg::CNT_W-1:0] next_opLeft;
  logic [flash_ctrl_pkg::CNT_W-1:0] next_busLeft;
  logic [31:0] next_prdata;
  logic        readDone;
  logic        sfEvent;
  logic        dfEvent;

  // Bus decode: no wait state, write takes effect in the access phase
  assign setupPhase = psel && !penable && !pready;
  assign wrStrobe   = psel && penable && pready && pwrite;

  always_comb begin
    unique case (paddr)
      flash_ctrl_pkg::ADDR_CLKDIV, flash_ctrl_pkg::ADDR_SEC, flash_ctrl_pkg::ADDR_CNFG,
      flash_ctrl_pkg::ADDR_ERCNFG, flash_ctrl_pkg::ADDR_STAT, flash_ctrl_pkg::ADDR_ERSTAT,
      flash_ctrl_pkg::ADDR_PPROT, flash_ctrl_pkg::ADDR_EPROT, flash_ctrl_pkg::ADDR_OPT,
      flash_ctrl_pkg::ADDR_CMDCODE, flash_ctrl_pkg::ADDR_CMDADDR,
      flash_ctrl_pkg::ADDR_MODE, flash_ctrl_pkg::ADDR_INFOROW: knownAddr = 1'b1;
      default: knownAddr = 1'b0;
    endcase
  end

  // Read data mux, sampled in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      flash_ctrl_pkg::ADDR_CLKDIV:  next_prdata = {24'h000000, dividerLoaded, 1'b0, dividerValue};
      flash_ctrl_pkg::ADDR_SEC:     next_prdata = {24'h000000, securityByte};
      flash_ctrl_pkg::ADDR_CNFG:    next_prdata = {24'h000000, cmd_complete_irq_en, 2'b00, ignoreSf, 2'b00,
                                                   forceDf, forceSf};
      flash_ctrl_pkg::ADDR_ERCNFG:  next_prdata = {30'h0000_0000, dfIrqEn, sfIrqEn};
      flash_ctrl_pkg::ADDR_STAT:    next_prdata = {24'h000000, cmdCompleteFlag, 1'b0, accessError,
                                                   protViolation, 4'h0};
      flash_ctrl_pkg::ADDR_ERSTAT:  next_prdata = {30'h0, doubleFaultFlag, singleFaultFlag};
      flash_ctrl_pkg::ADDR_PPROT:   next_prdata = {24'h000000, pflashProt};
      flash_ctrl_pkg::ADDR_EPROT:   next_prdata = {24'h000000, eepromProt};
      flash_ctrl_pkg::ADDR_OPT:     next_prdata = {24'h000000, optionByte};
      flash_ctrl_pkg::ADDR_CMDCODE: next_prdata = {24'h000000, cmdCode};
      flash_ctrl_pkg::ADDR_CMDADDR: next_prdata = {14'h0000, cmdAddr};
      flash_ctrl_pkg::ADDR_MODE:    next_prdata = {27'h0000000, nvMode, VERSION};
      flash_ctrl_pkg::ADDR_INFOROW: next_prdata = nvMode ? INFO_ROW : 32'h0000_0000;
      default:                      next_prdata = 32'h0000_0000;
    endcase
  end

  // APB answer registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= !knownAddr || (!pwrite && paddr == flash_ctrl_pkg::ADDR_INFOROW && !nvMode);
      end
    end
  end

  // Configuration and error enable registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_complete_irq_en     <= 1'b0;
      ignoreSf <= 1'b0;
      forceDf  <= 1'b0;
      forceSf  <= 1'b0;
      dfIrqEn  <= 1'b0;
      sfIrqEn  <= 1'b0;
      nvMode   <= 1'b0;
    end else if (wrStrobe) begin
      if (paddr == flash_ctrl_pkg::ADDR_CNFG) begin
        cmd_complete_irq_en     <= pwdata[flash_ctrl_pkg::BIT_CMD_COMPLETE_IRQ_EN];
        ignoreSf <= pwdata[flash_ctrl_pkg::BIT_IGNORE_SINGLE_FAULT];
        forceDf  <= pwdata[flash_ctrl_pkg::BIT_FORCE_DOUBLE_FAULT]; // Cleared only by writing zero or by reset
        forceSf  <= pwdata[flash_ctrl_pkg::BIT_FORCE_SINGLE_FAULT]; // Cleared only by writing zero or by reset
      end
      if (paddr == flash_ctrl_pkg::ADDR_ERCNFG) begin
        dfIrqEn <= pwdata[flash_ctrl_pkg::BIT_DOUBLE_FAULT_IRQ_EN];
        sfIrqEn <= pwdata[flash_ctrl_pkg::BIT_SINGLE_FAULT_IRQ_EN];
      end
      if (paddr == flash_ctrl_pkg::ADDR_MODE) begin
        nvMode <= pwdata[flash_ctrl_pkg::BIT_NVMODE];
      end
    end
  end

  // Divider register; any write marks it loaded
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dividerValue  <= '0;
      dividerLoaded <= 1'b0;
    end else if (wrStrobe && paddr == flash_ctrl_pkg::ADDR_CLKDIV) begin
      dividerValue  <= pwdata[flash_ctrl_pkg::DIV_W-1:0];
      dividerLoaded <= 1'b1;
    end
  end

  // Operation clock enable: one pulse every dividerValue+1 bus cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divCount <= '0;
      opTick   <= 1'b0;
    end else if (divCount >= dividerValue) begin
      divCount <= '0;
      opTick   <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      opTick   <= 1'b0;
    end
  end

  // Command object registers, frozen while a command runs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmdCode <= 8'h00;
      cmdAddr <= 18'h0_0000;
    end else if (wrStrobe && cmdCompleteFlag) begin
      if (paddr == flash_ctrl_pkg::ADDR_CMDCODE) cmdCode <= pwdata[7:0];
      if (paddr == flash_ctrl_pkg::ADDR_CMDADDR) cmdAddr <= pwdata[17:0];
    end
  end

  // Command classification and region protection check
  always_comb begin
    isPgmErs     = 1'b0;
    isKnownCmd   = 1'b1;
    next_opLeft  = '0;
    next_busLeft = '0;
    unique case (cmdCode)
      flash_ctrl_pkg::CMD_ERSVFY_ALL: begin
        next_opLeft  = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::OPC_ERSVFY);
        next_busLeft = flash_ctrl_pkg::CNT_W'(BUSC_ERSVFY);
      end
      flash_ctrl_pkg::CMD_PGM_PF: begin
        isPgmErs     = 1'b1;
        next_opLeft  = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::OPC_PGM_PF);
        next_busLeft = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::BUSC_PGM_PF);
      end
      flash_ctrl_pkg::CMD_ERS_PFBLK: begin
        isPgmErs     = 1'b1;
        next_opLeft  = flash_ctrl_pkg::CNT_W'(OPC_ERS_PF);
        next_busLeft = flash_ctrl_pkg::CNT_W'(BUSC_ERS_PF);
      end
      flash_ctrl_pkg::CMD_PGM_EE: begin
        isPgmErs     = 1'b1;
        next_opLeft  = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::OPC_PGM_EE);
        next_busLeft = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::BUSC_PGM_EE);
      end
      flash_ctrl_pkg::CMD_VFY_KEY: begin // Key stays in the array field
        next_opLeft  = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::OPC_VFY_KEY);
        next_busLeft = flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::BUSC_VFY_KEY);
      end
      default: isKnownCmd = 1'b0;
    endcase
  end

  // Protected region hit for program flash and EEPROM program commands
  always_comb begin
    protHit = 1'b0;
    if (cmdCode == flash_ctrl_pkg::CMD_PGM_PF) begin
      if (cmdAddr < flash_ctrl_pkg::PFLASH_LO) begin
        protHit = 1'b0;
      end else if (cmdAddr > flash_ctrl_pkg::HIGHREG_TOP - flash_ctrl_pkg::HIGHREG_SIZE) begin
        protHit = pflashProt[flash_ctrl_pkg::BIT_PROT_HI];
      end else if (cmdAddr >= flash_ctrl_pkg::LOWREG_START &&
                   cmdAddr < flash_ctrl_pkg::LOWREG_START + flash_ctrl_pkg::LOWREG_SIZE) begin
        protHit = pflashProt[flash_ctrl_pkg::BIT_PROT_LO];
      end else begin
        protHit = pflashProt[flash_ctrl_pkg::BIT_PROT_MID];
      end
    end else if (cmdCode == flash_ctrl_pkg::CMD_ERS_PFBLK) begin
      protHit = |pflashProt[flash_ctrl_pkg::BIT_PROT_MID:flash_ctrl_pkg::BIT_PROT_HI];
    end else if (cmdCode == flash_ctrl_pkg::CMD_PGM_EE) begin
      protHit = eepromProt[0];
    end
  end

  assign launchWrite = wrStrobe && paddr == flash_ctrl_pkg::ADDR_STAT &&
                       pwdata[flash_ctrl_pkg::BIT_CCF] && cmdCompleteFlag;
  assign launchOk    = launchWrite && !accessError && !protViolation && isKnownCmd &&
                       !(isPgmErs && !dividerLoaded) && !protHit;

  // Sequencer: reset load of config bytes, then command timing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state           <= flash_ctrl_pkg::ST_INIT_REQ; // Running command dropped
      cmdCompleteFlag <= 1'b0;
      initIdx         <= 2'd0;
      initFault       <= 1'b0;
      opLeft          <= '0;
      busLeft         <= '0;
    end else begin
      unique case (state)
        flash_ctrl_pkg::ST_INIT_REQ: state <= flash_ctrl_pkg::ST_INIT_WAIT;
        flash_ctrl_pkg::ST_INIT_WAIT: begin
          if (arrayResp.valid) begin
            initBytes[initIdx] <= arrayResp.data;
            if (arrayResp.doubleFault) initFault <= 1'b1;
            if (initIdx == 2'd3) begin
              state           <= flash_ctrl_pkg::ST_IDLE;
              cmdCompleteFlag <= 1'b1;
            end else begin
              initIdx <= initIdx + 2'd1;
              state   <= flash_ctrl_pkg::ST_INIT_REQ;
            end
          end
        end
        flash_ctrl_pkg::ST_IDLE: begin
          if (launchOk) begin
            cmdCompleteFlag <= 1'b0;
            opLeft          <= next_opLeft;
            busLeft         <= next_busLeft;
            state           <= flash_ctrl_pkg::ST_EXEC_OP;
          end
        end
        flash_ctrl_pkg::ST_EXEC_OP: begin
          if (opLeft == '0) state <= flash_ctrl_pkg::ST_EXEC_BUS;
          else if (opTick) opLeft <= opLeft - 1'b1;
        end
        flash_ctrl_pkg::ST_EXEC_BUS: begin
          if (busLeft <= 1) begin
            cmdCompleteFlag <= 1'b1;
            state           <= flash_ctrl_pkg::ST_IDLE;
          end else begin
            busLeft <= busLeft - 1'b1;
          end
        end
        default: state <= flash_ctrl_pkg::ST_INIT_REQ;
      endcase
    end
  end

  // Array read port driven during the reset load
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      arrayReadReq <= 1'b0;
      arrayAddr    <= flash_ctrl_pkg::CFG_FIRST;
    end else begin
      arrayReadReq <= state == flash_ctrl_pkg::ST_INIT_REQ;
      arrayAddr    <= flash_ctrl_pkg::CFG_FIRST + {16'h0000, initIdx};
    end
  end

  assign readDone = state == flash_ctrl_pkg::ST_INIT_WAIT && arrayResp.valid;

  // Protection, option and security bytes; defaults when the load saw a double fault
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pflashProt   <= flash_ctrl_pkg::DEF_PPROT;
      eepromProt   <= flash_ctrl_pkg::DEF_EPROT;
      optionByte   <= flash_ctrl_pkg::DEF_OPT;
      securityByte <= flash_ctrl_pkg::DEF_SEC;
    end else if (readDone && initIdx == 2'd3) begin
      if (initFault || arrayResp.doubleFault) begin
        pflashProt   <= flash_ctrl_pkg::DEF_PPROT;
        eepromProt   <= flash_ctrl_pkg::DEF_EPROT;
        optionByte   <= flash_ctrl_pkg::DEF_OPT;
        securityByte <= flash_ctrl_pkg::DEF_SEC;
      end else begin
        pflashProt   <= initBytes[0];
        eepromProt   <= initBytes[1];
        optionByte   <= initBytes[2];
        securityByte <= arrayResp.data;
      end
    end else if (wrStrobe && cmdCompleteFlag) begin
      if (paddr == flash_ctrl_pkg::ADDR_PPROT) pflashProt <= pwdata[7:0];
      if (paddr == flash_ctrl_pkg::ADDR_EPROT) eepromProt <= pwdata[7:0];
    end
  end

  // Fault events on each array read, forced or real
  assign sfEvent = readDone && ((arrayResp.singleFault && !ignoreSf) || forceSf);
  assign dfEvent = readDone && (arrayResp.doubleFault || forceDf);

  // Sticky status flags, write one to clear, set beats clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      accessError     <= 1'b0;
      protViolation   <= 1'b0;
      doubleFaultFlag <= 1'b0;
      singleFaultFlag <= 1'b0;
    end else begin
      accessError   <= (accessError && !(wrStrobe && paddr == flash_ctrl_pkg::ADDR_STAT &&
                       pwdata[flash_ctrl_pkg::BIT_ACCESS_ERROR_FLAG])) ||
                       (launchWrite && !accessError && !protViolation &&
                       (!isKnownCmd || (isPgmErs && !dividerLoaded)));
      protViolation <= (protViolation && !(wrStrobe && paddr == flash_ctrl_pkg::ADDR_STAT &&
                       pwdata[flash_ctrl_pkg::BIT_PVIOL])) ||
                       (launchWrite && !accessError && !protViolation && isKnownCmd &&
                       !(isPgmErs && !dividerLoaded) && protHit);
      doubleFaultFlag <= (doubleFaultFlag && !(wrStrobe && paddr == flash_ctrl_pkg::ADDR_ERSTAT &&
                         pwdata[flash_ctrl_pkg::BIT_DFDF])) || dfEvent;
      singleFaultFlag <= (singleFaultFlag && !(wrStrobe && paddr == flash_ctrl_pkg::ADDR_ERSTAT &&
                         pwdata[flash_ctrl_pkg::BIT_SFDF])) || sfEvent;
    end
  end

  // Interrupt and busy outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmdCompleteIrq <= 1'b0;
      faultIrq       <= 1'b0;
      cmdBusy        <= 1'b0;
    end else begin
      cmdCompleteIrq <= cmd_complete_irq_en && cmdCompleteFlag;
      faultIrq       <= (dfIrqEn && doubleFaultFlag) || (sfIrqEn && singleFaultFlag);
      cmdBusy        <= state inside {flash_ctrl_pkg::ST_EXEC_OP, flash_ctrl_pkg::ST_EXEC_BUS};
    end
  end

endmodule // flash_command_protection_ctrl

`default_nettype wire

// ==== verif/flash_ctrl_sva.sv ====
// Port checker for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_sva (
  // Watched ports
  input wire logic        clk_sys, reset, psel, penable, pready,
  input wire logic        arrayReadReq, cmdBusy, cmdCompleteIrq,
  input wire logic [17:0] arrayAddr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Bus answer timing, load start and address, command span
  chk_ready_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_load_start: assert property ($fell(reset) |-> ##[1:4] arrayReadReq)
    else $error("no load after reset");
  chk_load_addr: assert property (arrayReadReq |-> arrayAddr inside
    {[flash_ctrl_pkg::CFG_FIRST:flash_ctrl_pkg::CFG_LAST]}) else $error("load address");
  chk_req_pulse: assert property (arrayReadReq |=> !arrayReadReq)
    else $error("read request held");
  chk_addr_hold: assert property (!arrayReadReq |-> $stable(arrayAddr))
    else $error("address moved");
  chk_busy_min: assert property ($rose(cmdBusy) |-> cmdBusy[*8])
    else $error("command too short");
  chk_launch_irq: assert property ($rose(cmdBusy) |-> ##2 !cmdCompleteIrq)
    else $error("irq while busy");
endmodule // flash_ctrl_sva
bind flash_command_protection_ctrl flash_ctrl_sva u_sva (.clk_sys, .reset, .psel,
  .penable, .pready, .arrayReadReq, .cmdBusy, .cmdCompleteIrq, .arrayAddr);
`default_nettype wire

// ==== verif/flash_array_model.sv ====
// Flash array model answering configuration byte reads
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // Request side
  input  wire logic        clk_sys, reset, arrayReadReq, dfIn,
  input  wire logic [17:0] arrayAddr,
  input  wire logic [31:0] cfg,
  // Answer side
  output var flash_ctrl_pkg::arrayResp_t arrayResp
);
  logic [2:0] cnt;
  logic [1:0] idx;
  // Reply a few cycles late; data turns over between replies
  always_ff @(posedge clk_sys) begin
    if (reset) cnt <= '0;
    else if (arrayReadReq) {cnt, idx} <= {3'd5, arrayAddr[1:0]};
    else if (cnt != 3'd0) cnt <= cnt - 3'd1;
    if (cnt == 3'd1) arrayResp <= {1'b1, cfg[idx*8 +: 8], 1'b0, dfIn};
    else arrayResp <= {1'b0, ~arrayResp.data, 2'b00};
  end
endmodule // flash_array_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, reset, psel, penable, pwrite, dfIn, e;
  logic        pready, pslverr, arrayReadReq, cmdCompleteIrq, faultIrq, cmdBusy;
  logic [7:0]  paddr;
  logic [17:0] arrayAddr;
  logic [31:0] pwdata, prdata, cfg, r, v;
  flash_ctrl_pkg::arrayResp_t arrayResp;
  int          fail_count, n_tests, seed, div, n, x;
  logic [7:0]  cmds [5] = '{8'h01, 8'h06, 8'h09, 8'h0c, 8'h11};
  flash_command_protection_ctrl #(.BUSC_ERSVFY(20), .OPC_ERS_PF(30), .BUSC_ERS_PF(20),
    .INFO_ROW(32'h0000_a5c3)) u_dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .arrayReadReq, .arrayAddr, .arrayResp,
    .cmdCompleteIrq, .faultIrq, .cmdBusy);
  flash_array_model u_arr (.clk_sys, .reset, .arrayReadReq, .dfIn, .arrayAddr, .cfg,
    .arrayResp);
  // Clock and watchdog
  initial begin clk_sys = 0; forever #2 clk_sys = ~clk_sys; end
  initial begin #100000; fail_count++; finish_test; end
  // Expected command span in bus cycles
  function automatic int dur(input logic [7:0] c, input int d);
    case (c)
      8'h06: return flash_ctrl_pkg::OPC_PGM_PF * (d + 1) + flash_ctrl_pkg::BUSC_PGM_PF;
      8'h09: return 30 * (d + 1) + 20;
      8'h0c: return flash_ctrl_pkg::BUSC_VFY_KEY;
      8'h11: return flash_ctrl_pkg::OPC_PGM_EE * (d + 1) + flash_ctrl_pkg::BUSC_PGM_EE;
      default: return 20;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin fail_count++; $display("Error %0t: %h not %h", $time, got, exp); end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    seed = 10; {fail_count, n_tests} = '0; {psel, penable, pwrite, paddr, pwdata, dfIn} = '0;
    reset = 1; cfg = $random(seed); // Config phrase
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    apb(0, flash_ctrl_pkg::ADDR_STAT); chk(r[7], 0);
    repeat (60) @(posedge clk_sys);
    apb(0, flash_ctrl_pkg::ADDR_STAT); chk(r[7], 1);
    for (n = 0; n < 4; n++) begin
      apb(0, n == 3 ? flash_ctrl_pkg::ADDR_SEC : 8'(8'h18 + 4 * n));
      chk(r, {24'h0, cfg[n*8 +: 8]});
    end
    apb(0, flash_ctrl_pkg::ADDR_MODE); chk(r[3:0], flash_ctrl_pkg::VER_FIRST);
    apb(0, flash_ctrl_pkg::ADDR_INFOROW); chk(e, 1);
    apb(1, flash_ctrl_pkg::ADDR_MODE, 32'h10);
    apb(0, flash_ctrl_pkg::ADDR_INFOROW); chk(r, 32'h0000_a5c3);
    apb(0, 8'h40); chk({e, r[30:0]}, 32'h8000_0000);
    v = $random(seed) & 32'h93;
    apb(1, flash_ctrl_pkg::ADDR_CNFG, v); apb(0, flash_ctrl_pkg::ADDR_CNFG); chk(r, v);
    apb(1, flash_ctrl_pkg::ADDR_ERCNFG, 3);
    apb(0, flash_ctrl_pkg::ADDR_ERCNFG); chk(r, 3);
    apb(0, flash_ctrl_pkg::ADDR_CLKDIV); chk(r[7], 0);
    apb(1, flash_ctrl_pkg::ADDR_CMDCODE, 8'h06); apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h80);
    apb(0, flash_ctrl_pkg::ADDR_STAT); chk({r[5], cmdBusy}, 2'b10);
    apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h20);
    div = $random(seed) & 3;
    apb(1, flash_ctrl_pkg::ADDR_CLKDIV, div); apb(0, flash_ctrl_pkg::ADDR_CLKDIV);
    chk(r, 32'h80 | div);
    // Program into a protected high region is refused with a violation
    apb(1, flash_ctrl_pkg::ADDR_PPROT, 1 << flash_ctrl_pkg::BIT_PROT_HI);
    apb(1, flash_ctrl_pkg::ADDR_CMDADDR, flash_ctrl_pkg::HIGHREG_TOP);
    apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h80);
    apb(0, flash_ctrl_pkg::ADDR_STAT); chk({r[4], cmdBusy}, 2'b10);
    apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h10);
    // High region protection set above and random loaded EEPROM protection would refuse the command loop below
    apb(1, flash_ctrl_pkg::ADDR_PPROT, 0);
    apb(1, flash_ctrl_pkg::ADDR_EPROT, 0);
    apb(1, flash_ctrl_pkg::ADDR_CNFG, 32'h80);
    foreach (cmds[i]) begin
      apb(1, flash_ctrl_pkg::ADDR_CMDCODE, cmds[i]); apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h80);
      apb(1, flash_ctrl_pkg::ADDR_CMDCODE, 32'h3f);
      apb(0, flash_ctrl_pkg::ADDR_CMDCODE); chk(r, cmds[i]);
      n = 7; x = dur(cmds[i], div);
      while (cmdBusy === 1'b1) begin @(posedge clk_sys); n++; end
      chk(n > x - 10 && n < x + 10, 1);
      repeat (2) @(posedge clk_sys); chk(cmdCompleteIrq, 1);
    end
    apb(1, flash_ctrl_pkg::ADDR_CMDCODE, 8'h11); apb(1, flash_ctrl_pkg::ADDR_STAT, 32'h80);
    reset <= 1; dfIn <= 1;
    repeat (16) @(posedge clk_sys); chk(cmdBusy, 0);
    reset <= 0;
    repeat (60) @(posedge clk_sys);
    apb(0, flash_ctrl_pkg::ADDR_PPROT); chk(r, flash_ctrl_pkg::DEF_PPROT);
    apb(0, flash_ctrl_pkg::ADDR_SEC); chk(r, flash_ctrl_pkg::DEF_SEC);
    apb(0, flash_ctrl_pkg::ADDR_ERSTAT); chk(r, 1 << flash_ctrl_pkg::BIT_DFDF);
    chk(faultIrq, 0);
    apb(1, flash_ctrl_pkg::ADDR_ERCNFG, 1 << flash_ctrl_pkg::BIT_DOUBLE_FAULT_IRQ_EN);
    repeat (2) @(posedge clk_sys); chk(faultIrq, 1);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
